// >>> adcc_asserts.sv
/*
  Port checker for the converter control top.
  Assumes one clock and a synchronous active-high reset; bound below.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Inputs watched
  input wire adcc_pkg::adcc_ctrl_t ctrl_i,
  input wire logic [7:0] port_direction_control_i,
  input wire logic [7:0] port_pullup_prog_i,
  // Outputs watched
  input wire logic conversion_busy_flag_o,
  input wire logic converter_irq_request_o,
  input wire logic irq_o,
  input wire adcc_pkg::adcc_result_t result_o,
  input wire logic converter_powered_o,
  input wire logic converter_reset_o,
  input wire logic bandgap_route_o,
  input wire logic [2:0] channel_route_o,
  input wire adcc_pkg::adcc_pins_t pins_o,
  input wire logic [7:0] port_dir_eff_o
);
  // ----------------------------------------------------------------
  // Relations at the ports
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_rise_busy: assert property ($rose(ctrl_i.start) |=> conversion_busy_flag_o && converter_reset_o)
    else $error("start rise without busy and reset");
  // Shortest conversion is sixteen cycles, so eight is safe for every divide
  a_launch_busy: assert property ($fell(ctrl_i.start) && converter_reset_o
    |=> conversion_busy_flag_o [*8])
    else $error("busy dropped early after launch");
  a_done_irq: assert property ($fell(conversion_busy_flag_o) |-> converter_irq_request_o)
    else $error("no irq request at end");
  a_result_update: assert property ($changed(result_o) |-> $fell(conversion_busy_flag_o))
    else $error("result moved outside end");
  a_irq_gate: assert property (irq_o == (converter_irq_request_o && ctrl_i.global_irq_enable
    && ctrl_i.converter_irq_enable))
    else $error("irq gating wrong");
  a_power_map: assert property (converter_powered_o != ctrl_i.converter_power_off)
    else $error("power state wrong");
  a_ref_map: assert property (pins_o.vref_pin_sel == ctrl_i.reference_source_sel
    && pins_o.vref_other_fn_en != ctrl_i.reference_source_sel)
    else $error("reference pin wrong");
  a_pin_override: assert property (pins_o.digital_en == ~ctrl_i.analog_pin_enables
    && pins_o.pullup_en == (port_pullup_prog_i & ~ctrl_i.analog_pin_enables))
    else $error("pin override wrong");
  a_dir_override: assert property (port_dir_eff_o
    == (port_direction_control_i | ctrl_i.analog_pin_enables))
    else $error("direction override wrong");
  a_chan_route: assert property (bandgap_route_o == ctrl_i.bandgap_channel_sel
    && channel_route_o == ctrl_i.input_channel_sel)
    else $error("channel route wrong");
endmodule

bind adcc_top adcc_asserts adcc_asserts_inst (.mclk_i, .rst_i, .ctrl_i,
  .port_direction_control_i, .port_pullup_prog_i, .conversion_busy_flag_o,
  .converter_irq_request_o, .irq_o, .result_o, .converter_powered_o,
  .converter_reset_o, .bandgap_route_o, .channel_route_o, .pins_o, .port_dir_eff_o);

`default_nettype wire

// >>> adcc_clk_div.sv
/*
  Converter clock divider: a counter held clear by restart_i yields a one-cycle
  enable pulse at fsys divided by 1,2,4,...,64.
  Assumes the select input comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_clk_div (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control
  input wire logic restart_i,
  input wire logic [2:0] sel_i,
  // Enable
  output logic tick_o
);

  typedef struct packed {
    logic [adcc_pkg::DIV_W-1:0] cnt;
  } adcc_div_state_t;

  adcc_div_state_t s_reg;
  adcc_div_state_t s_next;
  logic [adcc_pkg::DIV_W-1:0] mask;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Undefined setting treated as the slowest rate, the safe choice
  always_comb begin
    s_next = s_reg;
    if (sel_i == adcc_pkg::DIV_SEL_UNDEF) begin
      mask = {adcc_pkg::DIV_W{1'b1}};
    end else begin
      mask = adcc_pkg::DIV_W'((7'h01 << sel_i) - 7'h01);
    end
    if (restart_i) begin
      s_next.cnt = '0;
    end else if ((s_reg.cnt & mask) == mask) begin
      s_next.cnt = '0;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  assign tick_o = ((s_reg.cnt & mask) == mask) && !restart_i;

  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule
`default_nettype wire

// >>> adcc_pkg.sv
/*
  Package for the converter control block: field widths, reset values,
  timing constants, state enumeration and carrier structs.
  Assumes a single 250 MHz system clock and no other shared types.
*/
package adcc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_PERIODS = 16;
  localparam logic [4:0] CONV_PERIODS_LAST = 5'h0f;
  localparam int DIV_W = 6;
  localparam logic [2:0] DIV_SEL_MAX = 3'h6;
  localparam logic [2:0] DIV_SEL_UNDEF = 3'h7;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int PINS = 8;
  localparam logic [11:0] FULL_SCALE = 12'hfff;
  localparam logic POWER_OFF_RST = 1'h1;
  localparam logic BUSY_RST = 1'h1;
  localparam logic [7:0] PIN_EN_RST = 8'hff;
  localparam logic [3:0] LOW_PAD = 4'h0;
  localparam logic [3:0] HIGH_PAD = 4'h0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_HELD,
    ADCC_CONV
  } adcc_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic converter_power_off;
    logic result_justify_sel;
    logic [2:0] input_channel_sel;
    logic bandgap_channel_sel;
    logic reference_source_sel;
    logic [2:0] conv_clock_divide_sel;
    logic [7:0] analog_pin_enables;
    logic global_irq_enable;
    logic converter_irq_enable;
  } adcc_ctrl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } adcc_result_t;

  typedef struct packed {
    logic [7:0] dir_in;
    logic [7:0] pullup_en;
    logic [7:0] digital_en;
    logic vref_pin_sel;
    logic vref_other_fn_en;
  } adcc_pins_t;

endpackage

// >>> adcc_result_fmt.sv
/*
  Result formatter: places the 12-bit code into the high and low
  data bytes, left or right justified.
  Pure combinational; the caller registers the output.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_result_fmt (
  // Inputs
  input wire logic [11:0] code_i,
  input wire logic justify_i,
  // Output
  output adcc_pkg::adcc_result_t res_o
);

  // ----------------------------------------------------------------
  // Justification
  // ----------------------------------------------------------------
  always_comb begin
    if (justify_i) begin
      res_o = {adcc_pkg::HIGH_PAD, code_i};
    end else begin
      res_o = {code_i, adcc_pkg::LOW_PAD};
    end
  end

endmodule
`default_nettype wire

// >>> adcc_top.sv
/*
  Converter control: start sequencing, busy flag, interrupt request,
  clock divider, power, reference and pin overrides, result capture.
  Assumes control bits arrive from CPU registers on mclk_i; the analog
  sample code arrives from the analog core and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control bits from software
  input wire adcc_pkg::adcc_ctrl_t ctrl_i,
  input wire logic irq_request_clear_i,
  // Port configuration from the pin logic
  input wire logic [7:0] port_direction_control_i,
  input wire logic [7:0] port_pullup_prog_i,
  // Analog core
  input wire logic [11:0] sample_code_i,
  // Status
  output logic conversion_busy_flag_o,
  output logic converter_irq_request_o,
  output logic irq_o,
  output adcc_pkg::adcc_result_t result_o,
  // Analog core control
  output logic converter_powered_o,
  output logic converter_reset_o,
  output logic bandgap_route_o,
  output logic [2:0] channel_route_o,
  output logic conv_clock_tick_o,
  // Pin overrides
  output adcc_pkg::adcc_pins_t pins_o,
  output logic [7:0] port_dir_eff_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    adcc_pkg::adcc_state_t st;
    logic start_d;
    logic busy;
    logic irq_req;
    logic [4:0] periods;
    logic [11:0] code_s1;
    logic [11:0] code_s2;
    adcc_pkg::adcc_result_t result;
  } adcc_top_state_t;

  adcc_top_state_t s_reg;
  adcc_top_state_t s_next;
  logic tick;
  logic div_restart;
  logic rise;
  logic fall;
  logic done;
  adcc_pkg::adcc_result_t fmt;

  // ----------------------------------------------------------------
  // Converter clock enable
  // ----------------------------------------------------------------
  // Divider restarts at launch so every period is a whole one
  assign div_restart = (s_reg.st != adcc_pkg::ADCC_CONV);

  adcc_clk_div u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .restart_i(div_restart),
    .sel_i(ctrl_i.conv_clock_divide_sel),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Result formatting
  // ----------------------------------------------------------------
  adcc_result_fmt u_fmt (
    .code_i(s_reg.code_s2),
    .justify_i(ctrl_i.result_justify_sel),
    .res_o(fmt)
  );

  // Start edges, software side on same clock
  assign rise = ctrl_i.start && !s_reg.start_d;
  assign fall = !ctrl_i.start && s_reg.start_d;
  assign done = (s_reg.st == adcc_pkg::ADCC_CONV) && tick &&
                (s_reg.periods == adcc_pkg::CONV_PERIODS_LAST);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.start_d = ctrl_i.start;
    // Analog code crosses in through two flops
    s_next.code_s1 = sample_code_i;
    s_next.code_s2 = s_reg.code_s1;
    unique case (s_reg.st)
      adcc_pkg::ADCC_IDLE: begin
        if (rise) begin
          s_next.st = adcc_pkg::ADCC_HELD;
          s_next.busy = 1'b1;
        end
      end
      adcc_pkg::ADCC_HELD: begin
        s_next.busy = 1'b1;
        if (fall && !ctrl_i.converter_power_off) begin
          s_next.st = adcc_pkg::ADCC_CONV;
          s_next.periods = '0;
        end else if (fall) begin
          // Powered off: nothing to convert, stay idle with flag high
          s_next.st = adcc_pkg::ADCC_IDLE;
        end
      end
      adcc_pkg::ADCC_CONV: begin
        if (rise) begin
          // A fresh start pulse aborts and resets the converter
          s_next.st = adcc_pkg::ADCC_HELD;
        end else if (ctrl_i.converter_power_off) begin
          s_next.st = adcc_pkg::ADCC_IDLE;
        end else if (done) begin
          s_next.st = adcc_pkg::ADCC_IDLE;
          s_next.busy = 1'b0;
          s_next.irq_req = 1'b1;
          s_next.result = fmt;
        end else if (tick) begin
          s_next.periods = s_reg.periods + 5'h01;
        end
      end
    endcase
    // Set wins over a clear in the same cycle
    if (irq_request_clear_i && !done) begin
      s_next.irq_req = 1'b0;
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= adcc_pkg::ADCC_IDLE;
      s_reg.busy <= adcc_pkg::BUSY_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  assign conversion_busy_flag_o = s_reg.busy;
  assign converter_irq_request_o = s_reg.irq_req;
  assign irq_o = s_reg.irq_req && ctrl_i.converter_irq_enable &&
                 ctrl_i.global_irq_enable;
  assign result_o = s_reg.result;

  // ----------------------------------------------------------------
  // Analog core control
  // ----------------------------------------------------------------
  assign converter_powered_o = !ctrl_i.converter_power_off;
  assign converter_reset_o = (s_reg.st == adcc_pkg::ADCC_HELD);
  assign bandgap_route_o = ctrl_i.bandgap_channel_sel;
  assign channel_route_o = ctrl_i.input_channel_sel;
  assign conv_clock_tick_o = tick;

  // ----------------------------------------------------------------
  // Pin overrides
  // ----------------------------------------------------------------
  // Direction forced to input (1) on analog pins
  always_comb begin
    pins_o.dir_in = ctrl_i.analog_pin_enables;
    pins_o.pullup_en = port_pullup_prog_i & ~ctrl_i.analog_pin_enables;
    pins_o.digital_en = ~ctrl_i.analog_pin_enables;
    pins_o.vref_pin_sel = ctrl_i.reference_source_sel;
    pins_o.vref_other_fn_en = !ctrl_i.reference_source_sel;
  end

  assign port_dir_eff_o = port_direction_control_i | ctrl_i.analog_pin_enables;

endmodule
`default_nettype wire

// >>> adcc_top_bench.sv
/*
  Self-checking bench for the converter control top.
  Assumes the checker is bound in; no other modules.
*/
`timescale 1ns/1ps
`default_nettype none

module adcc_top_bench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic clr = 1'b0;
  logic [7:0] dir = 8'h00;
  logic [7:0] pu = 8'h00;
  logic [11:0] code = 12'h000;
  adcc_pkg::adcc_ctrl_t ctrl = '0;
  adcc_pkg::adcc_result_t res;
  adcc_pkg::adcc_pins_t pins;
  logic busy, irq_req, irq, pwr, rst_o, bg, tick;
  logic [2:0] chan;
  logic [7:0] dir_eff;
  int mismatches = 0;
  int check_count = 0;
  int seed = 32'h1464;
  int n;
  int div;

  adcc_top adcc_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ctrl_i(ctrl),
    .irq_request_clear_i(clr), .port_direction_control_i(dir), .port_pullup_prog_i(pu),
    .sample_code_i(code), .conversion_busy_flag_o(busy), .converter_irq_request_o(irq_req),
    .irq_o(irq), .result_o(res), .converter_powered_o(pwr), .converter_reset_o(rst_o),
    .bandgap_route_o(bg), .channel_route_o(chan), .conv_clock_tick_o(tick),
    .pins_o(pins), .port_dir_eff_o(dir_eff));

  // ----------------------------------------------------------------
  // Clock, compare and closing
  // ----------------------------------------------------------------
  always #2 mclk_i = ~mclk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One launch pulse, then time the busy span against sixteen periods
  task automatic convert(input logic [2:0] sel, input logic just);
    adcc_pkg::adcc_ctrl_t c;
    // One assignment of ctrl per edge: fields are built in a local copy first
    c = 23'($random(seed));
    c.converter_power_off = 1'b0;
    c.conv_clock_divide_sel = sel;
    c.result_justify_sel = just;
    c.start = 1'b1;
    @(posedge mclk_i);
    code <= 12'($random(seed));
    {dir, pu} <= 16'($random(seed));
    ctrl <= c;
    @(posedge mclk_i) ctrl.start <= 1'b0;
    #1 chk({busy, rst_o}, 2'h3);
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge mclk_i);
      #1 n++;
    end
    // Divide select 111 behaves as the slowest setting
    div = 1 << ((sel == 3'h7) ? 6 : sel);
    chk(n >= 16 * div + 1 && n <= 16 * div + 2, 1);
    chk(irq_req, 1);
    chk(irq, ctrl.global_irq_enable & ctrl.converter_irq_enable);
    chk(res, just ? {4'h0, code} : {code, 4'h0});
    chk(pins, {ctrl.analog_pin_enables, pu & ~ctrl.analog_pin_enables,
      ~ctrl.analog_pin_enables, ctrl.reference_source_sel,
      ~ctrl.reference_source_sel});
    chk(dir_eff, dir | ctrl.analog_pin_enables);
    chk({bg, chan}, {ctrl.bandgap_channel_sel, ctrl.input_channel_sel});
    @(posedge mclk_i) clr <= 1'b1;
    @(posedge mclk_i) clr <= 1'b0;
    #1 chk(irq_req, 0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1 chk({busy, irq_req, res}, {1'b1, 1'b0, 16'h0000});
    for (int i = 0; i < 16; i++) begin
      convert(i[2:0], i[3]);
    end
    // Power dropped mid-conversion must not report completion
    @(posedge mclk_i) ctrl.start <= 1'b1;
    @(posedge mclk_i) ctrl.start <= 1'b0;
    repeat (5) @(posedge mclk_i);
    ctrl.converter_power_off <= 1'b1;
    repeat (2000) @(posedge mclk_i);
    #1 chk({busy, irq_req, pwr}, 3'h4);
    wrap_up();
  end

  // Hang guard well beyond the longest expected run
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
endmodule

`default_nettype wire
